// ### pwm_pkg.sv
// Purpose: shared constants and types for the eight-channel pwm timer
// Assumes: 32-bit axi4-lite register bus, one register per aligned word
// Notes: all counters run on aclk; all but the prescaler step on single-cycle enable pulses
package pwm_pkg;

  localparam int NCH = 8;

  // register byte offsets
  localparam logic [7:0] OFS_ENABLE = 8'h00;
  localparam logic [7:0] OFS_POLARITY = 8'h04;
  localparam logic [7:0] OFS_CLK_SEL = 8'h08;
  localparam logic [7:0] OFS_AB_SEL = 8'h0C;
  localparam logic [7:0] OFS_PRESCALE = 8'h10;
  localparam logic [7:0] OFS_CENTER = 8'h14;
  localparam logic [7:0] OFS_CONTROL = 8'h18;
  localparam logic [7:0] OFS_SCALE_A = 8'h1C;
  localparam logic [7:0] OFS_SCALE_B = 8'h20;
  localparam logic [7:0] OFS_COUNTER = 8'h40;
  localparam logic [7:0] OFS_PERIOD = 8'h60;
  localparam logic [7:0] OFS_DUTY = 8'h80;

  // field positions
  localparam int PCKA_LSB = 0;
  localparam int PCKB_LSB = 4;
  localparam int FRZ_BIT = 0;
  localparam logic [7:0] PRESC_MASK = 8'h77;

  // values after reset
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_AB_SEL = 8'hCC;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_DUTY = 8'hFF;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;

  typedef struct packed {
    logic en;
    logic pol;
    logic cae;
  } chan_cfg_t;

endpackage

// ### pwm_chan.sv
// Purpose: one 8-bit pwm channel with double-buffered period and duty
// Assumes: tick is a one-cycle pulse of the selected channel clock
// Notes: pwm output lags the output flip-flop by one aclk cycle
`timescale 1ns/100ps
module pwm_chan
  import pwm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire chan_cfg_t cfg,
  input wire logic per_wr,
  input wire logic dty_wr,
  input wire logic cnt_wr,
  input wire logic [7:0] wbyte,
  output logic [7:0] cnt,
  output logic [7:0] per_buf,
  output logic [7:0] dty_buf,
  output logic pwm
);

  logic [7:0] per_q, dty_q, per_act_q, dty_act_q, cnt_q, nxt, per_nx, dty_nx;
  logic ff_q, en_sync_q, pwm_q, step, wrap, turn, load;
  dir_t dir_q;

  ////////////////////////////////////////////////////////////////////////////
  // enable taken only at a channel clock edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_sync_q <= 1'b0;
    end else if (tick) begin
      en_sync_q <= cfg.en;
    end
  end

  assign step = en_sync_q && tick;

  always_comb begin
    nxt = (cfg.cae && dir_q == DIR_DOWN) ? cnt_q - 8'h01 : cnt_q + 8'h01;
    turn = cfg.cae && dir_q == DIR_UP && nxt == per_act_q;
    wrap = cfg.cae ? (dir_q == DIR_DOWN && nxt == RST_ZERO) : (nxt == per_act_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, direction and output flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= RST_ZERO;
      dir_q <= DIR_UP;
      ff_q <= 1'b0;
    end else if (cnt_wr) begin
      cnt_q <= RST_ZERO;
      dir_q <= DIR_UP;
      ff_q <= 1'b0;
    end else if (!cfg.en && tick && per_act_q == RST_ZERO) begin
      cnt_q <= RST_ZERO;
    end else if (step) begin
      cnt_q <= (wrap && !cfg.cae) ? RST_ZERO : nxt;
      if (turn) begin
        dir_q <= DIR_DOWN;
      end else if (wrap) begin
        dir_q <= DIR_UP;
      end
      ff_q <= wrap ? 1'b0 : (nxt == dty_act_q) ^ ff_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // double buffering of period and duty
  assign per_nx = per_wr ? wbyte : per_q;
  assign dty_nx = dty_wr ? wbyte : dty_q;
  assign load = cnt_wr || !cfg.en || (step && wrap);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_q <= RST_PERIOD;
      dty_q <= RST_DUTY;
      per_act_q <= RST_PERIOD;
      dty_act_q <= RST_DUTY;
    end else begin
      per_q <= per_nx;
      dty_q <= dty_nx;
      if (load) begin
        per_act_q <= per_nx;
        dty_act_q <= dty_nx;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= cfg.en && (cfg.pol ^ ff_q);
    end
  end

  assign cnt = cnt_q;
  assign per_buf = per_q;
  assign dty_buf = dty_q;
  assign pwm = pwm_q;

  ////////////////////////////////////////////////////////////////////////////
  a_cnt_write_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_wr |=> cnt_q == RST_ZERO && dir_q == DIR_UP) else $error("counter write did not clear");
  a_stop_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    !en_sync_q && !cnt_wr && !(tick && per_act_q == RST_ZERO) |=> $stable(cnt_q))
    else $error("stopped counter moved");
  a_start_level: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_wr && cfg.en ##1 cfg.en |=> pwm_q == $past(cfg.pol)) else $error("wrong start level");
  a_left_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    step && !cnt_wr && !cfg.cae && cnt_q + 8'h01 == per_act_q |=> cnt_q == RST_ZERO)
    else $error("left aligned wrap missed");
  a_center_turn: assert property (@(posedge aclk) disable iff (!aresetn)
    step && !cnt_wr && turn |=> dir_q == DIR_DOWN && cnt_q == $past(per_act_q))
    else $error("center turn missed");

endmodule // pwm_chan

// ### pwm_timer.sv
// Purpose: eight-channel pwm timer with prescaler, scaled clocks, axi4-lite
// Assumes: freeze_mode is asynchronous to aclk
// Notes: only byte lane 0 of each register word is used
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module pwm_timer
  import pwm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic freeze_mode,
  output logic [NCH-1:0] pwm_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic in_array(input logic [7:0] a, input logic [7:0] base);
    return a[7:5] == base[7:5] && a[1:0] == 2'b00;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'b00 && a <= OFS_SCALE_B) || in_array(a, OFS_COUNTER)
      || in_array(a, OFS_PERIOD) || in_array(a, OFS_DUTY);
  endfunction

  function automatic logic div_tick(input logic [6:0] c, input logic [2:0] sel);
    logic [6:0] m;
    m = 7'((8'h01 << sel) - 8'h01);
    return (c & m) == m;
  endfunction

  function automatic logic chan_tick(input logic ab, input logic sc, input logic [3:0] t);
    return t[{ab, sc}];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic aw_hold_q, w_hold_q, wstb_q, bvalid_q, rvalid_q, wr_go, wr_en;
  logic [7:0] waddr_q, wbyte_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, rd_word;
  logic [7:0] en_q, pol_q, csel_q, absel_q, presc_q, cae_q;
  logic frz_stop_q, frz_s1_q, frz_s2_q, presc_run, tick_a, tick_b;
  logic [6:0] presc_cnt_q;
  logic [7:0] scl_q [2];
  logic [7:0] sdn_q [2];
  logic [1:0] half_q, src_tick, scl_wr, stick;
  logic [7:0] cnt_w [NCH];
  logic [7:0] per_w [NCH];
  logic [7:0] dty_w [NCH];

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order
  assign awready = !aw_hold_q && !bvalid_q;
  assign wready = !w_hold_q && !bvalid_q;
  assign wr_go = aw_hold_q && w_hold_q;
  assign wr_en = wr_go && wstb_q && addr_ok(waddr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      waddr_q <= RST_ZERO;
      wbyte_q <= RST_ZERO;
      wstb_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        waddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        wbyte_q <= wdata[7:0];
        wstb_q <= wstrb[0];
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= addr_ok(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  a_write_err: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && !addr_ok(waddr_q) |=> bresp_q == RESP_SLVERR) else $error("bad write address accepted");
  a_write_okay: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && addr_ok(waddr_q) |=> bresp_q == RESP_OKAY) else $error("good write address refused");
  a_write_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid_q && !bready |=> bvalid_q && $stable(bresp_q)) else $error("write response dropped");
  a_bad_no_effect: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && !addr_ok(waddr_q) |=> $stable(en_q) && $stable(pol_q)) else $error("bad write changed state");

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  always_comb begin
    rd_word = 32'h0000_0000;
    if (in_array(araddr, OFS_COUNTER)) begin
      rd_word[7:0] = cnt_w[araddr[4:2]];
    end else if (in_array(araddr, OFS_PERIOD)) begin
      rd_word[7:0] = per_w[araddr[4:2]];
    end else if (in_array(araddr, OFS_DUTY)) begin
      rd_word[7:0] = dty_w[araddr[4:2]];
    end else begin
      case (araddr)
        OFS_ENABLE: rd_word[7:0] = en_q;
        OFS_POLARITY: rd_word[7:0] = pol_q;
        OFS_CLK_SEL: rd_word[7:0] = csel_q;
        OFS_AB_SEL: rd_word[7:0] = absel_q;
        OFS_PRESCALE: rd_word[7:0] = presc_q;
        OFS_CENTER: rd_word[7:0] = cae_q;
        OFS_CONTROL: rd_word[FRZ_BIT] = frz_stop_q;
        OFS_SCALE_A: rd_word[7:0] = scl_q[0];
        OFS_SCALE_B: rd_word[7:0] = scl_q[1];
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  assign arready = !rvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  a_read_err: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready && !addr_ok(araddr) |=> rresp_q == RESP_SLVERR && rdata_q == 32'h0000_0000)
    else $error("bad read address accepted");
  a_read_okay: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready && addr_ok(araddr) |=> rresp_q == RESP_OKAY) else $error("good read address refused");
  a_read_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_q |-> rdata_q[31:8] == 24'h00_0000) else $error("upper read bits set");

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= RST_ZERO;
      pol_q <= RST_ZERO;
      csel_q <= RST_ZERO;
      absel_q <= RST_AB_SEL;
      presc_q <= RST_ZERO;
      cae_q <= RST_ZERO;
      frz_stop_q <= 1'b0;
    end else if (wr_en) begin
      case (waddr_q)
        OFS_ENABLE: en_q <= wbyte_q;
        OFS_POLARITY: pol_q <= wbyte_q;
        OFS_CLK_SEL: csel_q <= wbyte_q;
        OFS_AB_SEL: absel_q <= wbyte_q;
        OFS_PRESCALE: presc_q <= wbyte_q & PRESC_MASK;
        OFS_CENTER: cae_q <= wbyte_q;
        OFS_CONTROL: frz_stop_q <= wbyte_q[FRZ_BIT];
        default: ;
      endcase
    end
  end

  a_presc_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    (presc_q & ~PRESC_MASK) == 8'h00) else $error("prescale reserved bits set");

  ////////////////////////////////////////////////////////////////////////////
  // freeze input synchroniser and prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frz_s1_q <= 1'b0;
      frz_s2_q <= 1'b0;
    end else begin
      frz_s1_q <= freeze_mode;
      frz_s2_q <= frz_s1_q;
    end
  end

  assign presc_run = !(frz_s2_q && frz_stop_q) && (|en_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_cnt_q <= 7'h00;
    end else if (presc_run) begin
      presc_cnt_q <= presc_cnt_q + 7'h01;
    end
  end

  assign tick_a = presc_run && div_tick(presc_cnt_q, presc_q[PCKA_LSB +: 3]);
  assign tick_b = presc_run && div_tick(presc_cnt_q, presc_q[PCKB_LSB +: 3]);
  assign src_tick = {tick_b, tick_a};

  a_presc_step: assert property (@(posedge aclk) disable iff (!aresetn)
    presc_run |=> presc_cnt_q == $past(presc_cnt_q) + 7'h01) else $error("prescaler did not advance");
  a_undivided_a: assert property (@(posedge aclk) disable iff (!aresetn)
    presc_run && presc_q[PCKA_LSB +: 3] == 3'h0 |-> tick_a) else $error("undivided clock a missed");
  a_half_rate_b: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_b && presc_q[PCKB_LSB +: 3] == 3'h1 && !wr_en |=> !tick_b) else $error("clock b too fast");
  a_freeze_ticks: assert property (@(posedge aclk) disable iff (!aresetn)
    frz_s2_q && frz_stop_q |-> !tick_a && !tick_b) else $error("clock ticked in freeze");
  a_idle_ticks: assert property (@(posedge aclk) disable iff (!aresetn)
    en_q == RST_ZERO |-> !tick_a && !tick_b) else $error("clock ticked with all channels off");

  ////////////////////////////////////////////////////////////////////////////
  // scaled clocks: reloading down counter then divide by two
  for (genvar s = 0; s < 2; s++) begin : g_scale
    assign scl_wr[s] = wr_en && waddr_q == (s == 0 ? OFS_SCALE_A : OFS_SCALE_B);
    assign stick[s] = src_tick[s] && sdn_q[s] == 8'h01 && half_q[s];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        scl_q[s] <= RST_ZERO;
        sdn_q[s] <= RST_ZERO;
        half_q[s] <= 1'b0;
      end else if (scl_wr[s]) begin
        scl_q[s] <= wbyte_q;
        sdn_q[s] <= wbyte_q;
      end else if (src_tick[s]) begin
        if (sdn_q[s] == 8'h01) begin
          sdn_q[s] <= scl_q[s];
          half_q[s] <= !half_q[s];
        end else begin
          sdn_q[s] <= sdn_q[s] - 8'h01;
        end
      end
    end
  end

  a_scale_b_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    scl_wr[1] |=> sdn_q[1] == $past(wbyte_q) && scl_q[1] == $past(wbyte_q))
    else $error("scale b write did not reload");
  a_half_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    src_tick[0] && sdn_q[0] == 8'h01 && !scl_wr[0] |=> half_q[0] != $past(half_q[0]))
    else $error("scaled clock a not halved");
  a_half_toggle_b: assert property (@(posedge aclk) disable iff (!aresetn)
    src_tick[1] && sdn_q[1] == 8'h01 && !scl_wr[1] |=> half_q[1] != $past(half_q[1]))
    else $error("scaled clock b not halved");

  ////////////////////////////////////////////////////////////////////////////
  // channels
  for (genvar i = 0; i < NCH; i++) begin : g_chan
    chan_cfg_t cfg;
    logic ctick;
    assign cfg = '{en: en_q[i], pol: pol_q[i], cae: cae_q[i]};
    assign ctick = chan_tick(absel_q[i], csel_q[i], {stick[1], tick_b, stick[0], tick_a});

    pwm_chan u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(ctick),
      .cfg(cfg),
      .per_wr(wr_en && in_array(waddr_q, OFS_PERIOD) && waddr_q[4:2] == 3'(i)),
      .dty_wr(wr_en && in_array(waddr_q, OFS_DUTY) && waddr_q[4:2] == 3'(i)),
      .cnt_wr(wr_en && in_array(waddr_q, OFS_COUNTER) && waddr_q[4:2] == 3'(i)),
      .wbyte(wbyte_q),
      .cnt(cnt_w[i]),
      .per_buf(per_w[i]),
      .dty_buf(dty_w[i]),
      .pwm(pwm_out[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  a_scale_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    scl_wr[0] |=> sdn_q[0] == $past(wbyte_q) && scl_q[0] == $past(wbyte_q))
    else $error("scale write did not reload");
  a_freeze_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    (frz_s2_q && frz_stop_q) || en_q == RST_ZERO |=> $stable(presc_cnt_q))
    else $error("prescaler ran while stopped");
  a_default_sel: assert property (@(posedge aclk)
    !aresetn |=> absel_q == RST_AB_SEL && csel_q == RST_ZERO) else $error("wrong clock select reset");
  a_scale_full: assert property (@(posedge aclk) disable iff (!aresetn)
    src_tick[0] && !scl_wr[0] && sdn_q[0] == RST_ZERO |=> sdn_q[0] == 8'hFF)
    else $error("zero scale not full range");
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> bvalid_q && !aw_hold_q && !w_hold_q) else $error("write answer missing");
  a_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_q && !rready |=> rvalid_q && $stable(rdata_q)) else $error("read data dropped");
  a_off_low: assert property (@(posedge aclk) disable iff (!aresetn)
    en_q == RST_ZERO |=> pwm_out == 8'h00) else $error("disabled outputs not low");

endmodule // pwm_timer

// ### testbench.sv
// Purpose: self-checking bench for the eight-channel pwm timer
// Assumes: registers reached over axi4-lite, one aligned word each
// Notes: waveforms are judged by high and rising-edge counts over whole periods
`timescale 1ns/100ps
module testbench
  import pwm_pkg::*;
;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, freeze_mode = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v0, v1;
  logic [NCH-1:0] pwm_out;
  int mismatches = 0, compares = 0, hi, rs;
  typedef struct packed {logic [7:0] a, w, e, rst; logic [1:0] rp;} row_t;
  row_t rows [12] = '{
    '{OFS_POLARITY, 8'h5A, 8'h5A, 8'h00, RESP_OKAY}, '{OFS_CLK_SEL, 8'hA5, 8'hA5, 8'h00, RESP_OKAY},
    '{OFS_AB_SEL, 8'h33, 8'h33, 8'hCC, RESP_OKAY}, '{OFS_PRESCALE, 8'hFF, 8'h77, 8'h00, RESP_OKAY},
    '{OFS_CENTER, 8'h0F, 8'h0F, 8'h00, RESP_OKAY}, '{OFS_CONTROL, 8'h01, 8'h01, 8'h00, RESP_OKAY},
    '{OFS_SCALE_A, 8'h80, 8'h80, 8'h00, RESP_OKAY}, '{OFS_SCALE_B, 8'h7F, 8'h7F, 8'h00, RESP_OKAY},
    '{8'h6C, 8'h12, 8'h12, 8'hFF, RESP_OKAY}, '{8'h9C, 8'h34, 8'h34, 8'hFF, RESP_OKAY},
    '{8'h48, 8'h55, 8'h00, 8'h00, RESP_OKAY}, '{8'h30, 8'h11, 8'h00, 8'h00, RESP_SLVERR}};

  always #25 aclk = ~aclk;

  pwm_timer dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .freeze_mode(freeze_mode), .pwm_out(pwm_out));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic got;
    got = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0000_00, d};
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!got) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        r = bresp;
        got = 1;
      end
    end
    bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic got;
    got = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!got) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        got = 1;
      end
    end
    rready <= 0;
  endtask

  // settle, then count high cycles and rising edges of one channel
  task automatic meas(input int ch, input int settle, input int n);
    logic prev;
    repeat (settle) @(posedge aclk);
    prev = pwm_out[ch];
    hi = 0;
    rs = 0;
    repeat (n) begin
      @(posedge aclk);
      if (pwm_out[ch] === 1'b1) hi++;
      if (pwm_out[ch] === 1'b1 && prev === 1'b0) rs++;
      prev = pwm_out[ch];
    end
  endtask

  task automatic setup(input logic [7:0] ch, input logic [7:0] per, input logic [7:0] dty);
    wr(OFS_PERIOD + 8'(4 * ch), per);
    wr(OFS_DUTY + 8'(4 * ch), dty);
    wr(OFS_COUNTER + 8'(4 * ch), 8'h00);
  endtask

  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      chk(r, rows[i].rp, "write response");
      rd(rows[i].a, v0);
      chk(v0, {24'h0, rows[i].e}, "readback");
      chk(r, rows[i].rp, "read response");
    end
    $display("register table done");
    // reset again in mid-run and read the reset value of every table row
    @(posedge aclk);
    aresetn <= 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    chk(pwm_out, '0, "output after reset");
    foreach (rows[i]) begin
      rd(rows[i].a, v0);
      chk(v0, {24'h0, rows[i].rst}, "reset value");
    end
    $display("reset done");
    // left aligned, clock a undivided: period 4 duty 1
    setup(0, 8'h04, 8'h01);
    wr(OFS_ENABLE, 8'h01);
    meas(0, 12, 40);
    chk(hi, 30, "left pol0 high");
    chk(rs, 10, "left pol0 periods");
    wr(OFS_POLARITY, 8'h01);
    meas(0, 12, 40);
    chk(hi, 10, "left pol1 high");
    // buffered period takes effect at period end
    wr(OFS_PERIOD, 8'h08);
    rd(OFS_PERIOD, v0);
    chk(v0, 32'h0000_0008, "period buffer");
    meas(0, 16, 80);
    chk(rs, 10, "new period");
    rd(OFS_COUNTER, v0);
    chk(v0 < 32'h0000_0008, 1'b1, "count in range");
    $display("left aligned done");
    // disable freezes the count; counter write clears it
    wr(OFS_ENABLE, 8'h00);
    rd(OFS_COUNTER, v0);
    repeat (20) @(posedge aclk);
    rd(OFS_COUNTER, v1);
    chk(v1, v0, "frozen count");
    chk(pwm_out[0], 1'b0, "disabled output");
    wr(OFS_COUNTER, 8'hA7);
    rd(OFS_COUNTER, v0);
    chk(v0, 32'h0, "counter cleared");
    // center aligned, period 4 duty 1 polarity 0: eight-tick period
    wr(OFS_POLARITY, 8'h00);
    wr(OFS_CENTER, 8'h01);
    setup(0, 8'h04, 8'h01);
    wr(OFS_ENABLE, 8'h01);
    meas(0, 20, 80);
    chk(hi, 60, "center high");
    chk(rs, 10, "center periods");
    // counter write while running restarts the period at polarity level
    wr(OFS_COUNTER, 8'h00);
    rd(OFS_COUNTER, v0);
    chk(v0, 32'h0000_0002, "restarted count");
    $display("center aligned done");
    // scaled clock a: scale 2 gives a/4, period 4 duty 2 polarity 1
    wr(OFS_ENABLE, 8'h00);
    wr(OFS_CENTER, 8'h00);
    wr(OFS_POLARITY, 8'h01);
    wr(OFS_CLK_SEL, 8'h01);
    wr(OFS_SCALE_A, 8'h02);
    setup(0, 8'h04, 8'h02);
    wr(OFS_ENABLE, 8'h01);
    meas(0, 40, 160);
    chk(hi, 80, "scaled high");
    chk(rs, 10, "scaled periods");
    // scale zero counts as 256: a/512, period 2 duty 1
    wr(OFS_ENABLE, 8'h00);
    setup(0, 8'h02, 8'h01);
    wr(OFS_SCALE_A, 8'h00);
    wr(OFS_ENABLE, 8'h01);
    meas(0, 1100, 5120);
    chk(rs, 5, "full scale periods");
    chk(hi, 2560, "full scale high");
    $display("scaled clock done");
    // channel 2 on clock b prescaled by 8: period 4 duty 2 polarity 0
    wr(OFS_ENABLE, 8'h00);
    wr(OFS_CLK_SEL, 8'h00);
    wr(OFS_POLARITY, 8'h00);
    wr(OFS_PRESCALE, 8'h30);
    setup(2, 8'h04, 8'h02);
    wr(OFS_ENABLE, 8'h05);
    meas(2, 40, 320);
    chk(hi, 160, "clock b high");
    chk(rs, 10, "clock b periods");
    // freeze with stop bit holds the prescaler
    wr(OFS_CONTROL, 8'h01);
    freeze_mode <= 1;
    meas(2, 8, 320);
    chk(rs, 0, "frozen output");
    freeze_mode <= 0;
    wr(OFS_CONTROL, 8'h00);
    // disabled channel with period zero clears on the next tick
    wr(OFS_ENABLE, 8'h01);
    wr(OFS_PERIOD + 8'h08, 8'h00);
    repeat (24) @(posedge aclk);
    rd(OFS_COUNTER + 8'h08, v0);
    chk(v0, 32'h0, "period zero clear");
    $display("clock b and freeze done");
    stop_test();
  end
endmodule // testbench
